// *** verilog/bsc_exec.sv ***
/*
 Execution of bit-test-skip-if-set and subroutine call over a four-phase
 instruction cycle. Assumes program memory presents the fetched word on
 i_insn by each Q4, the register file answers i_rd_data in the phase after
 a read request, and the return stack takes a push in the cycle it is asked.
*/
//
// Behaviour
// - Pattern 01 11bb bfff ffff is bit-test-skip-if-set; a clear bit lets the next instruction run and no flag changes.
// - A set bit discards the prefetched instruction, runs a no-operation instead, making the test two cycles long.
// - First cycle of the test decodes in Q1, reads in Q2, processes in Q3 and writes nothing in Q4.
// - The extra cycle of a taken skip does nothing in any quarter phase.
// - A call pushes the address after the call onto the return stack top and changes no flag.
// - A call loads its 11-bit immediate into program counter bits 10 to 0.
// - A call copies bits 4 and 3 of the upper latch register into program counter bits 12 and 11.
// - A call takes two cycles: process, write target and push, then a cycle of no-operation.
`timescale 1ns/1ps
`include "bsc_consts.svh"

module bsc_exec
	import bsc_pkg::*;
(
	// Clock and reset
	input  wire logic                     i_mclk,
	input  wire logic                     i_rst,
	// Program memory
	input  wire logic [`BSC_INSN_W-1:0]   i_insn,
	input  wire logic                     i_insn_vld,
	output logic [`BSC_PC_W-1:0]          o_fetch_addr,
	// Register file
	output bsc_rd_t                       o_rd,
	input  wire logic [7:0]               i_rd_data,
	input  wire logic [4:0]               i_pc_upper_latch,
	// Return stack
	output bsc_push_t                     o_push,
	// Status
	output logic                          o_skip_taken,
	output logic                          o_call_taken,
	output logic                          o_nop_cycle,
	output bsc_phase_t                    o_phase
);

	// Opcode decoders shared by every stage that looks at the instruction register
	function automatic logic is_btss(input logic [`BSC_INSN_W-1:0] w);
		is_btss = (w & `BSC_BTSS_MASK) == `BSC_BTSS_MATCH;
	endfunction

	function automatic logic is_call(input logic [`BSC_INSN_W-1:0] w);
		is_call = (w & `BSC_CALL_MASK) == `BSC_CALL_MATCH;
	endfunction

	// A taken skip or a call throws away the prefetched word
	function automatic logic is_redirect(input logic [`BSC_INSN_W-1:0] w, input logic b);
		is_redirect = (is_btss(w) && b) || is_call(w);
	endfunction

	bsc_phase_t                 phase;
	logic                       q4_end;
	bsc_state_t                 state_q;
	logic [`BSC_INSN_W-1:0]     ir_q;
	logic [`BSC_PC_W-1:0]       pc_q;
	logic                       bit_q;
	logic                       skip_q;
	logic                       call_q;
	logic                       nop_q;
	bsc_rd_t                    rd_q;
	bsc_push_t                  push_q;
	logic [`BSC_BIDX_W-1:0]     bidx;
	logic [`BSC_PC_W-1:0]       target;
	logic [`BSC_FADDR_W-1:0]    faddr;
	logic                       live;
	logic                       do_btss;
	logic                       do_call;
	logic                       redirect;

	bsc_phase u_phase (
		.i_mclk   (i_mclk),
		.i_rst    (i_rst),
		.o_phase  (phase),
		.o_q4_end (q4_end)
	);

	// Only the first cycle of an instruction acts; the flush cycle stays inert
	always_comb begin
		live     = (state_q == BSC_EXEC);
		do_btss  = live && is_btss(ir_q);
		do_call  = live && is_call(ir_q);
		redirect = live && is_redirect(ir_q, bit_q);
	end

	assign faddr  = ir_q[`BSC_FADDR_W-1:0];
	assign bidx   = ir_q[`BSC_BIDX_LSB +: `BSC_BIDX_W];
	assign target = {i_pc_upper_latch[`BSC_LATCH_HI:`BSC_LATCH_LO],
	                 ir_q[`BSC_IMM_W-1:0]};

	// Instruction register: prefetched word loads at Q4; flushed word becomes a no-op
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			ir_q <= `BSC_NOP_INSN;
		end else if (q4_end) begin
			if (redirect) begin
				ir_q <= `BSC_NOP_INSN;
			end else if (i_insn_vld) begin
				ir_q <= i_insn;
			end else begin
				ir_q <= `BSC_NOP_INSN;
			end
		end
	end

	// Flush cycle sequencing
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			state_q <= BSC_EXEC;
		end else if (q4_end) begin
			case (state_q)
				BSC_EXEC: begin
					if (redirect) begin
						state_q <= BSC_FLUSH;
					end
				end
				BSC_FLUSH: state_q <= BSC_EXEC;
				default: state_q <= BSC_EXEC;
			endcase
		end
	end

	// Register read request stands during Q2; no write port exists, so Q4 never writes
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			rd_q.en   <= 1'h0;
			rd_q.addr <= '0;
		end else begin
			rd_q.en   <= (phase == BSC_Q1) && do_btss;
			rd_q.addr <= faddr;
		end
	end

	// Tested bit captured at the end of Q3 and dropped at the next Q1
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			bit_q <= 1'h0;
		end else if (phase == BSC_Q3 && live) begin
			bit_q <= is_btss(ir_q) && i_rd_data[bidx];
		end else if (phase == BSC_Q1) begin
			bit_q <= 1'h0;
		end
	end

	// Return address push raised for Q4; the counter already names the next word
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			push_q.en   <= 1'h0;
			push_q.addr <= `BSC_PC_RST;
		end else begin
			push_q.en <= (phase == BSC_Q3) && do_call;
			if ((phase == BSC_Q3) && do_call) begin
				push_q.addr <= pc_q;
			end
		end
	end

	// Program counter steps once per instruction cycle and jumps at a call's Q4
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			pc_q <= `BSC_PC_RST;
		end else if (q4_end) begin
			if (do_call) begin
				pc_q <= target;
			end else begin
				pc_q <= pc_q + `BSC_PC_STEP;
			end
		end
	end

	// Status pulses, one clock after the Q4 that decides them
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			skip_q <= 1'h0;
			call_q <= 1'h0;
		end else begin
			skip_q <= q4_end && do_btss && bit_q;
			call_q <= q4_end && do_call;
		end
	end

	// No-op indicator covers the whole flush cycle
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			nop_q <= 1'h0;
		end else if (q4_end) begin
			nop_q <= redirect;
		end
	end

	bsc_phase_t phase_oq;
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			phase_oq <= BSC_Q1;
		end else begin
			phase_oq <= phase;
		end
	end

	assign o_fetch_addr = pc_q;
	assign o_rd         = rd_q;
	assign o_push       = push_q;
	assign o_skip_taken = skip_q;
	assign o_call_taken = call_q;
	assign o_nop_cycle  = nop_q;
	assign o_phase      = phase_oq;

endmodule

// *** verilog/bsc_consts.svh ***
/*
 Constants for the bit-test-skip and call execution block: opcode patterns,
 field positions and widths. Assumes inclusion by bare name.
*/
`ifndef BSC_CONSTS_SVH
`define BSC_CONSTS_SVH

`define BSC_INSN_W        14
`define BSC_PC_W          13
`define BSC_FADDR_W       7
`define BSC_BIDX_W        3
`define BSC_IMM_W         11
`define BSC_BTSS_MASK     14'h3C00
`define BSC_BTSS_MATCH    14'h1C00
`define BSC_CALL_MASK     14'h3800
`define BSC_CALL_MATCH    14'h2000
`define BSC_BIDX_LSB      7
`define BSC_LATCH_HI      4
`define BSC_LATCH_LO      3
`define BSC_NOP_INSN      14'h0000
`define BSC_PC_RST        13'h0000
`define BSC_PC_STEP       13'h0001

`endif

// *** verilog/bsc_pkg.sv ***
/*
 Types shared by the execution block and its phase generator.
 Assumes bsc_consts.svh is on the include path.
*/
`include "bsc_consts.svh"

package bsc_pkg;

	typedef enum logic [1:0] {
		BSC_Q1 = 2'h0,
		BSC_Q2 = 2'h1,
		BSC_Q3 = 2'h3,
		BSC_Q4 = 2'h2
	} bsc_phase_t;

	typedef enum logic [1:0] {
		BSC_EXEC  = 2'h0,
		BSC_FLUSH = 2'h1
	} bsc_state_t;

	typedef struct packed {
		logic                       en;
		logic [`BSC_FADDR_W-1:0]    addr;
	} bsc_rd_t;

	typedef struct packed {
		logic                       en;
		logic [`BSC_PC_W-1:0]       addr;
	} bsc_push_t;

endpackage

// *** verilog/bsc_phase.sv ***
/*
 Quarter-phase generator: a Q1..Q4 phase code and a one-cycle Q4 enable for each instruction
 cycle, advancing one phase per clock. Assumes a single clock domain.
*/
`timescale 1ns/1ps

module bsc_phase
	import bsc_pkg::*;
(
	// Clock and reset
	input  wire logic       i_mclk,
	input  wire logic       i_rst,
	// Phase outputs
	output bsc_phase_t      o_phase,
	output logic            o_q4_end
);

	bsc_phase_t phase_q;

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			phase_q <= BSC_Q1;
		end else begin
			case (phase_q)
				BSC_Q1: phase_q <= BSC_Q2;
				BSC_Q2: phase_q <= BSC_Q3;
				BSC_Q3: phase_q <= BSC_Q4;
				BSC_Q4: phase_q <= BSC_Q1;
				default: phase_q <= BSC_Q1;
			endcase
		end
	end

	assign o_phase  = phase_q;
	assign o_q4_end = (phase_q == BSC_Q4);

endmodule

// *** verif/bsc_exec_chk.sv ***
/*
 Port assertions for the bit-test-skip and call execution block.
 Assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`include "bsc_consts.svh"

module bsc_exec_chk
	import bsc_pkg::*;
(
	// Watched ports
	input  wire logic                     i_mclk,
	input  wire logic                     i_rst,
	input  wire logic [`BSC_INSN_W-1:0]   i_insn,
	input  wire logic [4:0]               i_pc_upper_latch,
	input  wire logic [`BSC_PC_W-1:0]     o_fetch_addr,
	input  wire bsc_rd_t                  o_rd,
	input  wire bsc_push_t                o_push,
	input  wire logic                     o_skip_taken,
	input  wire logic                     o_call_taken,
	input  wire logic                     o_nop_cycle,
	input  wire bsc_phase_t               o_phase
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_rst);

	AST_RD_ADDR: assert property (o_rd.en |-> o_rd.addr == $past(i_insn[6:0], 2))
		else $error("read address differs from operand");
	AST_SKIP_SRC: assert property (o_skip_taken |-> $past(o_rd.en, 3))
		else $error("skip without a register read");
	AST_SKIP_NOP: assert property (o_skip_taken |-> o_nop_cycle [*4])
		else $error("skip not followed by four idle phases");
	AST_NOP_QUIET: assert property (o_nop_cycle |-> !o_rd.en && !o_push.en)
		else $error("activity during idle cycle");
	AST_PUSH_CALL: assert property (o_push.en |=> o_call_taken)
		else $error("push not followed by call pulse");
	AST_PUSH_ADDR: assert property (o_push.en |-> o_push.addr == 13'($past(o_fetch_addr, 4) + 13'h0001))
		else $error("return address wrong");
	AST_CALL_LOW: assert property (o_push.en |=> o_fetch_addr[10:0] == $past(i_insn[10:0], 5))
		else $error("call target low bits wrong");
	AST_CALL_HIGH: assert property (o_push.en |=> o_fetch_addr[12:11] == $past(i_pc_upper_latch[4:3]))
		else $error("call target high bits wrong");
	AST_CALL_NOP: assert property (o_call_taken |-> o_nop_cycle [*4])
		else $error("call second cycle not idle");
	AST_RD_PHASE: assert property (o_rd.en |-> o_phase == BSC_Q1)
		else $error("register read outside the read quarter");
	AST_SKIP_PHASE: assert property (o_skip_taken |-> o_phase == BSC_Q4)
		else $error("skip pulse not after a fourth quarter");
	AST_PHASE_WRAP: assert property (o_phase == BSC_Q4 |=> o_phase == BSC_Q1)
		else $error("quarter phase did not wrap");
endmodule

bind bsc_exec bsc_exec_chk bsc_exec_chk_inst (
	.i_mclk(i_mclk), .i_rst(i_rst), .i_insn(i_insn), .i_pc_upper_latch(i_pc_upper_latch),
	.o_fetch_addr(o_fetch_addr), .o_rd(o_rd), .o_push(o_push), .o_skip_taken(o_skip_taken),
	.o_call_taken(o_call_taken), .o_nop_cycle(o_nop_cycle), .o_phase(o_phase));

// *** verif/bsc_mem_model.sv ***
/*
 Program memory, register file and return stack beside the block.
 Assumes the bench loads mem and regs by hierarchical reference.
*/
`timescale 1ns/1ps

module bsc_mem_model
	import bsc_pkg::*;
(
	// Requests from the block
	input  wire logic          i_mclk,
	input  wire logic [12:0]   i_fetch_addr,
	input  wire bsc_rd_t       i_rd,
	input  wire bsc_push_t     i_push,
	// Answers
	output logic [13:0]        o_insn,
	output logic [7:0]         o_rd_data = 8'h00
);
	logic [13:0] mem [0:8191] = '{default: 14'h0000};
	logic [7:0]  regs [0:127] = '{default: 8'h00};
	logic [12:0] top_of_stack = 13'h0000;

	assign o_insn = mem[i_fetch_addr];
	always @(posedge i_mclk) begin
		// Outside a read the data lines toggle rather than hold
		o_rd_data <= i_rd.en ? regs[i_rd.addr] : ~o_rd_data;
		if (i_push.en)
			top_of_stack <= i_push.addr;
	end
endmodule

// *** verif/bit_skip_and_call_exec_tb_top.sv ***
/*
 Self-checking bench: skip set, skip clear and call scenarios.
 Assumes bsc_mem_model answers fetches, reads and pushes.
*/
`timescale 1ns/1ps

module bit_skip_and_call_exec_tb_top
	import bsc_pkg::*;
;
	logic        i_mclk = 0;
	logic        i_rst = 1;
	logic [4:0]  latch = 5'h18;
	logic [13:0] insn;
	logic [7:0]  rd_data;
	logic [12:0] fetch;
	bsc_rd_t     rd;
	bsc_push_t   push;
	logic        skip, call, nopc, hit;
	int          n_fail = 0, samples_checked = 0, n_skip, n_call, n_nop;

	always #20 i_mclk = ~i_mclk;

	bsc_exec bsc_exec_inst (.i_mclk(i_mclk), .i_rst(i_rst), .i_insn(insn), .i_insn_vld(1'h1),
		.o_fetch_addr(fetch), .o_rd(rd), .i_rd_data(rd_data), .i_pc_upper_latch(latch),
		.o_push(push), .o_skip_taken(skip), .o_call_taken(call), .o_nop_cycle(nopc), .o_phase());
	bsc_mem_model bsc_mem_model_inst (.i_mclk(i_mclk), .i_fetch_addr(fetch), .i_rd(rd),
		.i_push(push), .o_insn(insn), .o_rd_data(rd_data));

	always @(posedge i_mclk) begin
		if (!i_rst) begin
			n_skip += (skip === 1'h1);
			n_call += (call === 1'h1);
			n_nop += (nopc === 1'h1);
			if (fetch === 13'h1FFF)
				hit = 1;
		end
	end

	task chk_n(input int g, input int e);
		samples_checked++;
		if (g != e) begin
			n_fail++;
			$display("Error at %0t: count %0d expected %0d", $time, g, e);
		end
	endtask

	task chk_v(input logic [12:0] g, input logic [12:0] e);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("Error at %0t: address %h expected %h", $time, g, e);
		end
	endtask

	task run(input logic [13:0] w, input int c);
		bsc_mem_model_inst.mem[0] = w;
		bsc_mem_model_inst.regs[5] = 8'h08;
		@(posedge i_mclk) i_rst <= 1;
		repeat (2) @(posedge i_mclk);
		i_rst <= 0;
		n_skip = 0;
		n_call = 0;
		n_nop = 0;
		hit = 0;
		repeat (c) @(posedge i_mclk);
	endtask

	task t_skip_set;
		run(14'h1D85, 24);
		chk_n(n_skip, 1);
		chk_n(n_nop, 4);
		chk_n(n_call, 0);
		$display("skip set done");
	endtask

	task t_skip_clear;
		run(14'h1D05, 24);
		chk_n(n_skip, 0);
		chk_n(n_nop, 0);
		$display("skip clear done");
	endtask

	task t_call;
		run(14'h27FF, 18);
		chk_n(n_call, 1);
		chk_n(n_nop, 4);
		chk_v(bsc_mem_model_inst.top_of_stack, 13'h0001);
		chk_n(hit, 1);
		$display("call done");
	endtask

	task close_out;
		$display("Comparisons %0d, mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge i_mclk);
		t_skip_set;
		t_skip_clear;
		t_call;
		close_out;
	end
endmodule
